//--- uicfl_pkg.sv
// Shared constants and state encodings for the UART interrupt, queue and line control block
package uicfl_pkg;
  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [2:0] UICFL_IDX_HOLD = 3'h0;
  localparam logic [2:0] UICFL_IDX_ENABLE = 3'h1;
  localparam logic [2:0] UICFL_IDX_IDENT = 3'h2;
  localparam logic [2:0] UICFL_IDX_FORMAT = 3'h3;
  localparam logic [2:0] UICFL_IDX_LINE = 3'h5;
  localparam logic [2:0] UICFL_IDX_MODEM = 3'h6;
  // ****************************************
  // Identification codes
  // ****************************************
  localparam logic [3:0] UICFL_ID_LINE = 4'h6;
  localparam logic [3:0] UICFL_ID_TIMEOUT = 4'hC;
  localparam logic [3:0] UICFL_ID_RXDATA = 4'h4;
  localparam logic [3:0] UICFL_ID_TXEMPTY = 4'h2;
  localparam logic [3:0] UICFL_ID_MODEM = 4'h0;
  localparam logic [3:0] UICFL_ID_NONE = 4'h1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] UICFL_ENABLE_RST = 4'h0;
  localparam logic [4:0] UICFL_FORMAT_RST = 5'h00;
  localparam logic [1:0] UICFL_TRIG_RST = 2'h0;
  // ****************************************
  // Trigger levels and timing
  // ****************************************
  localparam logic [4:0] UICFL_TRIG_L0 = 5'h01;
  localparam logic [4:0] UICFL_TRIG_L1 = 5'h04;
  localparam logic [4:0] UICFL_TRIG_L2 = 5'h08;
  localparam logic [4:0] UICFL_TRIG_L3 = 5'h0E;
  localparam logic [3:0] UICFL_TICK_LAST = 4'hF;
  localparam logic [3:0] UICFL_HALF_LAST = 4'h7;
  localparam logic [5:0] UICFL_STOP1_LAST = 6'h0F;
  localparam logic [5:0] UICFL_STOP15_LAST = 6'h17;
  localparam logic [5:0] UICFL_STOP2_LAST = 6'h1F;
  localparam logic [6:0] UICFL_TIMEOUT_CHARS = 7'h04;
  localparam logic [6:0] UICFL_TIMEOUT_BITS = 7'h0C;
  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [2:0] {
    UICFL_RX_IDLE = 3'b000,
    UICFL_RX_START = 3'b001,
    UICFL_RX_DATA = 3'b010,
    UICFL_RX_PAR = 3'b011,
    UICFL_RX_STOP = 3'b100,
    UICFL_RX_BRK = 3'b101
  } uicfl_rx_type;
  typedef enum logic [2:0] {
    UICFL_TX_IDLE = 3'b000,
    UICFL_TX_START = 3'b001,
    UICFL_TX_DATA = 3'b010,
    UICFL_TX_PAR = 3'b011,
    UICFL_TX_STOP = 3'b100
  } uicfl_tx_type;
endpackage : uicfl_pkg

//--- uicfl_uart.sv
// UART channel with interrupt priority, queue control, line format and APB registers
//
// Behaviour
// - Line state bits 0,1,5,6 show data present, overrun, holding and shifter empty.
// - Line state bits 2-4 show head byte errors; bit 7 any queued error.
// - Receive data interrupt on held byte, or queue at trigger level.
// - Transmit ready interrupt when holding empties, or at enable if empty.
// - Overrun raises line interrupt at once; byte errors when byte at head.
// - Any modem change flag raises modem interrupt when enabled.
// - Enable bits 7:4 read zero; all enables reset to zero.
// - Identification shows only highest pending source.
// - Codes 0110, 1100, 0100, 0010, 0000; none pending reads 0001.
// - Timeout after four characters plus twelve bits without queue activity.
// - Line interrupt cleared by line state read; modem by modem read.
// - Data interrupt clears below trigger; timeout clears on holding read.
// - Transmit ready cleared by identification read or holding write.
// - Identification bits 7:6 show queues enabled; bits 5:4 zero.
// - Queue control bit 0 enables queues and gates other bits.
// - Queue reset bits clear pointers and counts, then self clear.
// - Queue control bit 3 selects DMA behaviour of ready pins.
// - Trigger levels 1, 4, 8, 14; bits 5:4 reserved.
// - Format bits 1:0 select five to eight data bits.
// - Format bit 2 gives one, one and a half, or two stops.
// - Format bit 3 enables parity; bit 4 selects odd or even.
`timescale 1ns/100ps
`default_nettype none
module uicfl_uart #(
  parameter int TICK_DIV = 108,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic irq,
  output logic transmit_ready_pin,
  output logic receive_ready_pin
);
  import uicfl_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic txd;
    logic irq;
    logic transmit_ready_pin_n;
    logic receive_ready_pin_n;
    logic [3:0] interrupt_enable;
    logic fifo_en;
    logic dma;
    logic [1:0] trig;
    logic [4:0] character_format;
    logic [15:0] div_cnt;
    logic tick;
    logic rx_s1;
    logic rx_s2;
    logic [3:0] m_s1;
    logic [3:0] m_s2;
    logic [3:0] m_prev;
    logic [3:0] delta;
    uicfl_rx_type rx_st;
    logic [3:0] rx_tc;
    logic [2:0] rx_bc;
    logic [7:0] rx_sh;
    logic rx_acc;
    logic rx_zero;
    logic ov;
    logic err_ack;
    logic [DEPTH-1:0][10:0] rx_mem;
    logic [AW-1:0] rx_wp;
    logic [AW-1:0] rx_rp;
    logic [AW:0] rx_cnt;
    logic [3:0] to_tc;
    logic [6:0] to_bits;
    logic to_flag;
    uicfl_tx_type tx_st;
    logic [5:0] tx_tc;
    logic [2:0] tx_bc;
    logic [7:0] tx_sh;
    logic tx_par;
    logic [DEPTH-1:0][7:0] tx_mem;
    logic [AW-1:0] tx_wp;
    logic [AW-1:0] tx_rp;
    logic [AW:0] tx_cnt;
    logic thr_int;
    logic emp_d;
  } uicfl_state_type;

  uicfl_state_type s;
  uicfl_state_type n;

  logic [2:0] idx;
  logic bad;
  logic done;
  logic [AW:0] cap;
  logic [AW:0] lvl;
  logic [7:0] line_state;
  logic [7:0] modem_state;
  logic [3:0] code;
  logic [10:0] head;
  logic fifo_err;
  logic rx_pop;
  logic rx_push;
  logic tx_push;
  logic [2:0] wl_last;
  logic [3:0] frame;
  logic [6:0] to_lim;
  logic [5:0] stop_last;
  logic [10:0] rx_word;
  logic qc_write;

  function automatic logic [AW:0] uicfl_trig(input logic [1:0] t);
    case (t)
      2'h0: uicfl_trig = (AW+1)'(UICFL_TRIG_L0);
      2'h1: uicfl_trig = (AW+1)'(UICFL_TRIG_L1);
      2'h2: uicfl_trig = (AW+1)'(UICFL_TRIG_L2);
      default: uicfl_trig = (AW+1)'(UICFL_TRIG_L3);
    endcase
  endfunction : uicfl_trig

  function automatic logic uicfl_live(input logic [AW-1:0] i, input logic [AW-1:0] rp,
                                      input logic [AW:0] cnt);
    logic [AW-1:0] d;
    d = i - rp;
    uicfl_live = ((AW+1)'(d) < cnt);
  endfunction : uicfl_live

  // ****************************************
  // Status decode
  // ****************************************
  always_comb begin
    idx = paddr[4:2];
    bad = (paddr[7:5] != 3'h0) || (paddr[1:0] != 2'h0) || (idx == 3'h4) || (idx == 3'h7);
    done = psel && penable && s.pready;
    cap = s.fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
    lvl = uicfl_trig(s.trig);
    head = s.rx_mem[s.rx_rp];
    if (s.rx_cnt == '0) begin
      head = '0;
    end
    fifo_err = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (uicfl_live(AW'(i), s.rx_rp, s.rx_cnt) && (s.rx_mem[i][10:8] != 3'h0)) begin
        fifo_err = 1'b1;
      end
    end
    line_state = {fifo_err, (s.tx_cnt == '0) && (s.tx_st == UICFL_TX_IDLE), s.tx_cnt == '0,
           head[10:8], s.ov, s.rx_cnt != '0};
    modem_state = {~s.m_s2[3], ~s.m_s2[2], ~s.m_s2[1], ~s.m_s2[0], s.delta};
    // Priority order of pending sources
    if (s.interrupt_enable[2] && (s.ov || ((head[10:8] != 3'h0) && !s.err_ack))) begin
      code = UICFL_ID_LINE;
    end else if (s.interrupt_enable[0] && s.to_flag) begin
      code = UICFL_ID_TIMEOUT;
    end else if (s.interrupt_enable[0] && (s.fifo_en ? (s.rx_cnt >= lvl) : (s.rx_cnt != '0))) begin
      code = UICFL_ID_RXDATA;
    end else if (s.interrupt_enable[1] && s.thr_int) begin
      code = UICFL_ID_TXEMPTY;
    end else if (s.interrupt_enable[3] && (s.delta != 4'h0)) begin
      code = UICFL_ID_MODEM;
    end else begin
      code = UICFL_ID_NONE;
    end
    wl_last = {1'b1, s.character_format[1:0]};
    frame = 4'h7 + {2'b00, s.character_format[1:0]} + {3'b000, s.character_format[3]} + {3'b000, s.character_format[2]};
    to_lim = 7'(frame) * UICFL_TIMEOUT_CHARS + UICFL_TIMEOUT_BITS;
    if (!s.character_format[2]) begin
      stop_last = UICFL_STOP1_LAST;
    end else if (s.character_format[1:0] == 2'h0) begin
      stop_last = UICFL_STOP15_LAST;
    end else begin
      stop_last = UICFL_STOP2_LAST;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = s;
    rx_pop = 1'b0;
    rx_push = 1'b0;
    tx_push = 1'b0;
    qc_write = 1'b0;
    rx_word = '0;
    // APB slave: answer in the first access cycle
    n.pready = psel && !penable && !s.pready;
    if (psel && !penable && !s.pready) begin
      n.pslverr = bad;
      n.prdata = 32'h00000000;
      case (idx)
        UICFL_IDX_HOLD: n.prdata = {24'h000000, head[7:0]};
        UICFL_IDX_ENABLE: n.prdata = {28'h0000000, s.interrupt_enable};
        UICFL_IDX_IDENT: n.prdata = {24'h000000, {2{s.fifo_en}}, 2'b00, code};
        UICFL_IDX_FORMAT: n.prdata = {27'h0000000, s.character_format};
        UICFL_IDX_LINE: n.prdata = {24'h000000, line_state};
        UICFL_IDX_MODEM: n.prdata = {24'h000000, modem_state};
        default: n.prdata = 32'h00000000;
      endcase
    end
    if (done && !bad) begin
      if (pwrite) begin
        case (idx)
          UICFL_IDX_HOLD: begin
            tx_push = (s.tx_cnt != cap);
            n.thr_int = 1'b0;
          end
          UICFL_IDX_ENABLE: n.interrupt_enable = pwdata[3:0];
          UICFL_IDX_IDENT: qc_write = 1'b1;
          UICFL_IDX_FORMAT: n.character_format = pwdata[4:0];
          default: n.interrupt_enable = s.interrupt_enable;
        endcase
      end else begin
        case (idx)
          UICFL_IDX_HOLD: rx_pop = (s.rx_cnt != '0);
          UICFL_IDX_IDENT: begin
            if (code == UICFL_ID_TXEMPTY) begin
              n.thr_int = 1'b0;
            end
          end
          UICFL_IDX_LINE: begin
            n.ov = 1'b0;
            n.err_ack = 1'b1;
          end
          UICFL_IDX_MODEM: n.delta = 4'h0;
          default: n.ov = s.ov;
        endcase
      end
    end
    // Tick divider for sixteen samples per bit
    n.tick = 1'b0;
    n.div_cnt = s.div_cnt + 16'h0001;
    if (s.div_cnt == 16'(TICK_DIV - 1)) begin
      n.div_cnt = 16'h0000;
      n.tick = 1'b1;
    end
    // Synchronisers and modem change flags
    n.rx_s1 = rxd;
    n.rx_s2 = s.rx_s1;
    n.m_s1 = {cd_n, ri_n, dsr_n, cts_n};
    n.m_s2 = s.m_s1;
    n.m_prev = s.m_s2;
    n.delta[0] = n.delta[0] | (s.m_s2[0] ^ s.m_prev[0]);
    n.delta[1] = n.delta[1] | (s.m_s2[1] ^ s.m_prev[1]);
    n.delta[2] = n.delta[2] | (s.m_s2[2] & ~s.m_prev[2]);
    n.delta[3] = n.delta[3] | (s.m_s2[3] ^ s.m_prev[3]);
    // Receiver
    case (s.rx_st)
      UICFL_RX_IDLE: begin
        if (!s.rx_s2) begin
          n.rx_st = UICFL_RX_START;
          n.rx_tc = 4'h0;
        end
      end
      UICFL_RX_START: begin
        if (s.tick) begin
          n.rx_tc = s.rx_tc + 4'h1;
          if (s.rx_tc == UICFL_HALF_LAST) begin
            n.rx_st = s.rx_s2 ? UICFL_RX_IDLE : UICFL_RX_DATA;
            n.rx_tc = 4'h0;
            n.rx_bc = 3'h0;
            n.rx_acc = 1'b0;
            n.rx_zero = 1'b1;
          end
        end
      end
      UICFL_RX_DATA: begin
        if (s.tick) begin
          n.rx_tc = s.rx_tc + 4'h1;
          if (s.rx_tc == UICFL_TICK_LAST) begin
            n.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
            n.rx_acc = s.rx_acc ^ s.rx_s2;
            n.rx_zero = s.rx_zero & !s.rx_s2;
            n.rx_bc = s.rx_bc + 3'h1;
            if (s.rx_bc == wl_last) begin
              n.rx_st = s.character_format[3] ? UICFL_RX_PAR : UICFL_RX_STOP;
            end
          end
        end
      end
      UICFL_RX_PAR: begin
        if (s.tick) begin
          n.rx_tc = s.rx_tc + 4'h1;
          if (s.rx_tc == UICFL_TICK_LAST) begin
            n.rx_acc = s.rx_acc ^ s.rx_s2;
            n.rx_zero = s.rx_zero & !s.rx_s2;
            n.rx_st = UICFL_RX_STOP;
          end
        end
      end
      UICFL_RX_STOP: begin
        if (s.tick) begin
          n.rx_tc = s.rx_tc + 4'h1;
          if (s.rx_tc == UICFL_TICK_LAST) begin
            rx_word[7:0] = 8'(s.rx_sh >> (2'h3 - s.character_format[1:0]));
            rx_word[8] = s.character_format[3] && (s.rx_acc == s.character_format[4]);
            rx_word[9] = !s.rx_s2;
            rx_word[10] = !s.rx_s2 && s.rx_zero;
            rx_push = 1'b1;
            n.rx_st = rx_word[10] ? UICFL_RX_BRK : UICFL_RX_IDLE;
          end
        end
      end
      UICFL_RX_BRK: begin
        if (s.rx_s2) begin
          n.rx_st = UICFL_RX_IDLE;
        end
      end
      default: n.rx_st = UICFL_RX_IDLE;
    endcase
    // Receive queue
    if (rx_push && (s.rx_cnt == cap) && !rx_pop) begin
      n.ov = 1'b1;
      rx_push = 1'b0;
    end
    if (rx_push) begin
      n.rx_mem[s.rx_wp] = rx_word;
      n.rx_wp = s.rx_wp + 1'b1;
    end
    if (rx_pop) begin
      n.rx_rp = s.rx_rp + 1'b1;
      n.to_flag = 1'b0;
    end
    if (rx_pop || (rx_push && (s.rx_cnt == '0))) begin
      n.err_ack = 1'b0;
    end
    n.rx_cnt = s.rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    // Receive timeout timer
    if (rx_push || rx_pop || !s.fifo_en || (s.rx_cnt == '0)) begin
      n.to_tc = 4'h0;
      n.to_bits = 7'h00;
    end else if (s.tick && !s.to_flag) begin
      n.to_tc = s.to_tc + 4'h1;
      if (s.to_tc == UICFL_TICK_LAST) begin
        n.to_bits = s.to_bits + 7'h01;
        if (s.to_bits + 7'h01 >= to_lim) begin
          n.to_flag = 1'b1;
        end
      end
    end
    // Transmitter
    case (s.tx_st)
      UICFL_TX_IDLE: begin
        if (s.tx_cnt != '0) begin
          n.tx_sh = s.tx_mem[s.tx_rp];
          n.tx_rp = s.tx_rp + 1'b1;
          n.tx_st = UICFL_TX_START;
          n.tx_tc = 6'h00;
        end
      end
      UICFL_TX_START: begin
        if (s.tick) begin
          n.tx_tc = s.tx_tc + 6'h01;
          if (s.tx_tc == 6'(UICFL_TICK_LAST)) begin
            n.tx_st = UICFL_TX_DATA;
            n.tx_tc = 6'h00;
            n.tx_bc = 3'h0;
            n.tx_par = 1'b0;
          end
        end
      end
      UICFL_TX_DATA: begin
        if (s.tick) begin
          n.tx_tc = s.tx_tc + 6'h01;
          if (s.tx_tc == 6'(UICFL_TICK_LAST)) begin
            n.tx_tc = 6'h00;
            n.tx_sh = {1'b0, s.tx_sh[7:1]};
            n.tx_par = s.tx_par ^ s.tx_sh[0];
            n.tx_bc = s.tx_bc + 3'h1;
            if (s.tx_bc == wl_last) begin
              n.tx_st = s.character_format[3] ? UICFL_TX_PAR : UICFL_TX_STOP;
            end
          end
        end
      end
      UICFL_TX_PAR: begin
        if (s.tick) begin
          n.tx_tc = s.tx_tc + 6'h01;
          if (s.tx_tc == 6'(UICFL_TICK_LAST)) begin
            n.tx_tc = 6'h00;
            n.tx_st = UICFL_TX_STOP;
          end
        end
      end
      UICFL_TX_STOP: begin
        if (s.tick) begin
          n.tx_tc = s.tx_tc + 6'h01;
          if (s.tx_tc == stop_last) begin
            n.tx_st = UICFL_TX_IDLE;
          end
        end
      end
      default: n.tx_st = UICFL_TX_IDLE;
    endcase
    if (tx_push) begin
      n.tx_mem[s.tx_wp] = pwdata[7:0];
      n.tx_wp = s.tx_wp + 1'b1;
    end
    n.tx_cnt = s.tx_cnt + (AW+1)'(tx_push)
               - (AW+1)'((s.tx_st == UICFL_TX_IDLE) && (s.tx_cnt != '0));
    // Transmit ready flag: set wins over clear
    n.emp_d = (s.tx_cnt == '0);
    if ((s.tx_cnt == '0) && !s.emp_d) begin
      n.thr_int = 1'b1;
    end
    if ((s.tx_cnt == '0) && n.interrupt_enable[1] && !s.interrupt_enable[1]) begin
      n.thr_int = 1'b1;
    end
    // Queue control write
    if (qc_write) begin
      n.fifo_en = pwdata[0];
      if (pwdata[0]) begin
        n.dma = pwdata[3];
        n.trig = pwdata[7:6];
      end
      if ((pwdata[0] && pwdata[1]) || (pwdata[0] != s.fifo_en)) begin
        n.rx_wp = '0;
        n.rx_rp = '0;
        n.rx_cnt = '0;
        n.to_flag = 1'b0;
      end
      if ((pwdata[0] && pwdata[2]) || (pwdata[0] != s.fifo_en)) begin
        n.tx_wp = '0;
        n.tx_rp = '0;
        n.tx_cnt = '0;
      end
    end
    // Line outputs and ready pins
    case (n.tx_st)
      UICFL_TX_START: n.txd = 1'b0;
      UICFL_TX_DATA: n.txd = n.tx_sh[0];
      UICFL_TX_PAR: n.txd = n.tx_par ^ ~s.character_format[4];
      default: n.txd = 1'b1;
    endcase
    n.irq = (code != UICFL_ID_NONE);
    if (s.dma) begin
      n.receive_ready_pin_n = !((s.rx_cnt >= lvl) || s.to_flag) || (s.rx_cnt == '0);
      n.transmit_ready_pin_n = (s.tx_cnt == cap);
    end else begin
      n.receive_ready_pin_n = (s.rx_cnt == '0);
      n.transmit_ready_pin_n = (s.tx_cnt != '0);
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.txd <= 1'b1;
      s.receive_ready_pin_n <= 1'b1;
      s.interrupt_enable <= UICFL_ENABLE_RST;
      s.character_format <= UICFL_FORMAT_RST;
      s.trig <= UICFL_TRIG_RST;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
      s.m_s1 <= 4'hF;
      s.m_s2 <= 4'hF;
      s.m_prev <= 4'hF;
      s.emp_d <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign txd = s.txd;
  assign irq = s.irq;
  assign transmit_ready_pin = s.transmit_ready_pin_n;
  assign receive_ready_pin = s.receive_ready_pin_n;
endmodule : uicfl_uart
`default_nettype wire

//--- uicfl_properties.sv
// Port-level checks for the UART interrupt, queue and line control block
`timescale 1ns/100ps
`default_nettype none
module uicfl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd,
  input wire logic irq
);
  typedef struct packed {
    logic [3:0] en;
    logic fe;
    logic [4:0] fmt;
  } uicfl_shadow_type;
  uicfl_shadow_type shadow;
  uicfl_shadow_type next_shadow;
  logic setup;
  logic rd;
  assign setup = psel && !penable;
  assign rd = setup && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Shadow of host writes
  // ****************************************
  always_comb begin
    next_shadow = shadow;
    if (psel && penable && pready && pwrite) begin
      if (paddr == 8'h04) next_shadow.en = pwdata[3:0];
      if (paddr == 8'h08) next_shadow.fe = pwdata[0];
      if (paddr == 8'h0C) next_shadow.fmt = pwdata[4:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) shadow <= '0;
    else shadow <= next_shadow;
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_ready; setup |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("pready not a single pulse");
  property p_unmapped; (setup && paddr == 8'h10) |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_enable_rd; (rd && paddr == 8'h04) |=> prdata == {28'h0, shadow.en}; endproperty
  a_enable_rd: assert property (p_enable_rd) else $error("enable readback wrong");
  property p_ident_hi;
    (rd && paddr == 8'h08) |=> prdata[31:4] == {24'h0, shadow.fe, shadow.fe, 2'h0};
  endproperty
  a_ident_hi: assert property (p_ident_hi) else $error("ident upper bits wrong");
  property p_ident_code;
    (rd && paddr == 8'h08) |=> prdata[3:0] inside {4'h6, 4'hC, 4'h4, 4'h2, 4'h0, 4'h1};
  endproperty
  a_ident_code: assert property (p_ident_code) else $error("ident code illegal");
  property p_quiet; (shadow.en == 4'h0) [*3] |-> !irq; endproperty
  a_quiet: assert property (p_quiet) else $error("irq with all sources masked");
  property p_line_rd;
    (rd && paddr == 8'h14) |=> (!prdata[6] || prdata[5]) && prdata[31:8] == 24'h0;
  endproperty
  a_line_rd: assert property (p_line_rd) else $error("line state bits inconsistent");
  property p_txd_bit; $fell(txd) |-> !txd [*8]; endproperty
  a_txd_bit: assert property (p_txd_bit) else $error("txd low bit too short");
  property p_fmt_rd; (rd && paddr == 8'h0C) |=> prdata == {27'h0, shadow.fmt}; endproperty
  a_fmt_rd: assert property (p_fmt_rd) else $error("format readback wrong");
endmodule : uicfl_properties
bind uicfl_uart uicfl_properties u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .txd(txd),
  .irq(irq)
);
`default_nettype wire

//--- uicfl_far_end.sv
// Remote serial device model on the UART line pins
`timescale 1ns/100ps
`default_nettype none
module uicfl_far_end #(
  parameter int BIT_CYC = 32
) (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd,
  input wire logic [3:0] cfg_bits,
  input wire logic cfg_par,
  input wire logic cfg_even,
  output logic [7:0] got_byte,
  output logic got_par_ok,
  output logic [7:0] got_count
);
  logic p;
  // ****************************************
  // Frame sender, idle line stays high
  // ****************************************
  task send(input logic [7:0] d, input logic bad);
    rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < cfg_bits; i++) begin
      rxd <= d[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    if (cfg_par) begin
      rxd <= ^d ^ !cfg_even ^ bad;
      repeat (BIT_CYC) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge pclk);
  endtask : send
  // ****************************************
  // Frame receiver, samples mid-bit
  // ****************************************
  initial begin
    rxd = 1'b1;
    got_byte = 8'h00;
    got_par_ok = 1'b0;
    got_count = 8'h00;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge pclk);
      p = 1'b0;
      got_byte = 8'h00;
      for (int i = 0; i < cfg_bits; i++) begin
        repeat (BIT_CYC) @(posedge pclk);
        got_byte[i] = txd;
        p = p ^ txd;
      end
      got_par_ok = 1'b1;
      if (cfg_par) begin
        repeat (BIT_CYC) @(posedge pclk);
        got_par_ok = ((p ^ txd) == !cfg_even);
      end
      repeat (BIT_CYC) @(posedge pclk);
      if (txd) got_count = got_count + 8'h01;
    end
  end
endmodule : uicfl_far_end
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the UART interrupt, queue and line control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, cts_n, irq, err;
  logic transmit_ready_pin, receive_ready_pin, cfg_par, cfg_even, got_par_ok, dsr_n, ri_n, cd_n;
  logic [31:0] prdata, pwdata, q;
  logic [7:0] paddr, got_byte, got_count, n0;
  logic [3:0] cfg_bits;
  logic [7:0] fm[4] = '{8'h03, 8'h1A, 8'h0D, 8'h04};
  int lv[4] = '{1, 4, 8, 14};
  int failures, cmp_count, cyc;
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  uicfl_uart #(.TICK_DIV(2)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
    .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .irq(irq),
    .transmit_ready_pin(transmit_ready_pin), .receive_ready_pin(receive_ready_pin));
  uicfl_far_end #(.BIT_CYC(32)) u_far (.pclk(pclk), .txd(txd), .rxd(rxd),
    .cfg_bits(cfg_bits), .cfg_par(cfg_par), .cfg_even(cfg_even), .got_byte(got_byte),
    .got_par_ok(got_par_ok), .got_count(got_count));
  // ****************************************
  // Helpers
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task rchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), q, {24'h0, e});
  endtask : rchk
  task wrap_up;
    $display("Checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, cfg_par, cfg_even} = 6'h0;
    {paddr, pwdata, cts_n, dsr_n, ri_n, cd_n, cfg_bits} = {8'h0, 32'h0, 4'hF, 4'h8};
    {failures, cmp_count, cyc} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(8'h04, 8'h00);
    rchk(8'h08, 8'h01);
    rchk(8'h0C, 8'h00);
    rchk(8'h14, 8'h60);
    xfer(1'b0, 8'h10, 8'h00);
    chk("slave error", err, 32'h1);
    xfer(1'b1, 8'h04, 8'hFF);
    rchk(8'h04, 8'h0F);
    rchk(8'h08, 8'h02);
    rchk(8'h08, 8'h01);
    xfer(1'b1, 8'h04, 8'h00);
    xfer(1'b1, 8'h0C, 8'hFF);
    rchk(8'h0C, 8'h1F);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 8'h0C, fm[k]);
      {cfg_bits, cfg_par, cfg_even} = {4'h5 + {2'h0, fm[k][1:0]}, fm[k][3], fm[k][4]};
      n0 = got_count;
      xfer(1'b1, 8'h00, 8'hA5);
      @(posedge pclk);
      chk("tx pin", transmit_ready_pin, 32'h1);
      for (int t = 0; t < 600 && got_count == n0; t++) @(posedge pclk);
      repeat (80) @(posedge pclk);
      chk("tx byte", got_byte, 8'hA5 & (8'hFF >> (3 - fm[k][1:0])));
      chk("tx parity", got_par_ok, 32'h1);
      chk("tx frames", got_count, n0 + 8'h01);
    end
    xfer(1'b1, 8'h0C, 8'h03);
    {cfg_bits, cfg_par, cfg_even} = {4'h8, 2'h0};
    xfer(1'b1, 8'h04, 8'h01);
    for (int t = 0; t < 4; t++) begin
      xfer(1'b1, 8'h08, {t[1:0], 6'h07});
      for (int b = 1; b < lv[t]; b++) u_far.send(b[7:0], 1'b0);
      rchk(8'h08, 8'hC1);
      u_far.send(8'h77, 1'b0);
      repeat (8) @(posedge pclk);
      rchk(8'h08, 8'hC4);
    end
    rchk(8'h00, 8'h01);
    rchk(8'h08, 8'hC1);
    chk("rx pin", receive_ready_pin, 32'h0);
    xfer(1'b1, 8'h08, 8'hCB);
    rchk(8'h14, 8'h60);
    chk("rx pin", receive_ready_pin, 32'h1);
    u_far.send(8'h55, 1'b0);
    repeat (8) @(posedge pclk);
    rchk(8'h08, 8'hC1);
    chk("rx pin dma", receive_ready_pin, 32'h1);
    repeat (1570) @(posedge pclk);
    rchk(8'h08, 8'hC1);
    repeat (930) @(posedge pclk);
    rchk(8'h08, 8'hCC);
    chk("rx pin dma", receive_ready_pin, 32'h0);
    chk("tx pin dma", transmit_ready_pin, 32'h0);
    rchk(8'h00, 8'h55);
    rchk(8'h08, 8'hC1);
    xfer(1'b1, 8'h04, 8'h05);
    xfer(1'b1, 8'h08, 8'h07);
    xfer(1'b1, 8'h0C, 8'h1B);
    {cfg_par, cfg_even} = 2'h3;
    u_far.send(8'h5A, 1'b1);
    repeat (8) @(posedge pclk);
    rchk(8'h08, 8'hC6);
    rchk(8'h14, 8'hE5);
    rchk(8'h08, 8'hC4);
    rchk(8'h00, 8'h5A);
    rchk(8'h14, 8'h60);
    xfer(1'b1, 8'h04, 8'h08);
    cts_n <= 1'b0;
    repeat (6) @(posedge pclk);
    rchk(8'h08, 8'hC0);
    rchk(8'h18, 8'h11);
    {cd_n, ri_n, dsr_n} <= 3'h0;
    repeat (6) @(posedge pclk);
    rchk(8'h18, 8'hFA);
    ri_n <= 1'b1;
    repeat (6) @(posedge pclk);
    rchk(8'h18, 8'hB4);
    rchk(8'h08, 8'hC1);
    xfer(1'b1, 8'h08, 8'hC8);
    rchk(8'h08, 8'h01);
    u_far.send(8'h33, 1'b0);
    repeat (8) @(posedge pclk);
    chk("rx pin gated", receive_ready_pin, 32'h0);
    u_far.send(8'h44, 1'b0);
    repeat (8) @(posedge pclk);
    rchk(8'h14, 8'h63);
    rchk(8'h14, 8'h61);
    rchk(8'h00, 8'h33);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
